/* File: src/isp_prog.sv */
// Programmer end: data FIFO, test clock divider and the six-stage sequencer.
`timescale 1ns/1ps
`default_nettype none
module isp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] count_r, count_nxt;
  logic ready_r, ready_nxt;
  logic push, pop;

  assign push = in_valid & ready_r;
  assign pop = out_valid & out_ready;
  assign out_valid = count_r != '0;
  assign out_data = buf_r[rp_r];
  assign in_ready = ready_r;

  always_comb
  begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
    ready_nxt = count_nxt != (PW+1)'(DEPTH);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
    if (push)
      buf_r[wp_r] <= in_data;
  end
endmodule

module isp_prog #(
  parameter int ENTER_CYC = isp_pkg::ENTER_CYC,
  parameter int EXIT_CYC = isp_pkg::EXIT_CYC,
  parameter int ERASE_CYC = isp_pkg::ERASE_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Test port link
  isp_link_if.prog link,
  // Run control
  input wire logic start,
  input wire logic verify_only,
  input wire logic [isp_pkg::ID_W-1:0] expected_id,
  // Pattern stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [isp_pkg::DATA_W-1:0] wr_data,
  // Result
  output logic busy,
  output logic done,
  output logic pass,
  output logic id_fail,
  output logic verify_fail,
  output logic [isp_pkg::ADDR_W-1:0] fail_addr
);
  typedef enum logic [3:0] {
    PS_IDLE = 4'h0,
    PS_IDCODE = 4'h1,
    PS_IDREAD = 4'h2,
    PS_IDCHK = 4'h3,
    PS_ERASE = 4'h4,
    PS_PROG = 4'h5,
    PS_VERIFY = 4'h6,
    PS_VREAD = 4'h7,
    PS_VCHK = 4'h8,
    PS_EXIT = 4'h9,
    PS_SHIFT = 4'ha,
    PS_WAIT = 4'hb,
    PS_DONE = 4'hc
  } isp_pstate_t;

  localparam int FB = isp_pkg::FRAME_BITS;
  localparam int DW = isp_pkg::DATA_W;
  localparam int AW = isp_pkg::ADDR_W;
  localparam int CW = isp_pkg::CNT_W;
  localparam int MG = isp_pkg::EXEC_MARGIN_CYC;
  localparam logic [2:0] HALF_LAST = 3'(isp_pkg::TCK_HALF_CYC - 1);
  localparam logic [2:0] FULL_LAST = 3'(2 * isp_pkg::TCK_HALF_CYC - 1);

  isp_pstate_t st_r, st_nxt, ret_r, ret_nxt;
  logic [FB-1:0] frame_r, frame_nxt, cap_r, cap_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [2:0] ph_r, ph_nxt;
  logic [CW-1:0] wait_r, wait_nxt;
  logic tck_r, tck_nxt, tms_r, tms_nxt, tdi_r, tdi_nxt;
  logic [AW:0] acnt_r, acnt_nxt;
  logic [DW-1:0] exp_r, exp_nxt;
  logic vonly_r, vonly_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, pass_r, pass_nxt;
  logic idf_r, idf_nxt, vf_r, vf_nxt;
  logic [AW-1:0] faddr_r, faddr_nxt;
  logic [1:0] tdo_sr_r;
  logic [DW-1:0] image [isp_pkg::NUM_ADDR];
  logic img_we;
  logic go;
  isp_pkg::isp_op_t go_op;
  logic [CW-1:0] go_wait;
  isp_pstate_t go_ret;
  logic f_valid, f_ready;
  logic [DW-1:0] f_data;
  logic addr_end;

  isp_fifo #(.WIDTH(DW), .DEPTH(isp_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign addr_end = acnt_r == (AW+1)'(isp_pkg::NUM_ADDR);

  always_comb
  begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    frame_nxt = frame_r;
    cap_nxt = cap_r;
    bit_nxt = bit_r;
    ph_nxt = ph_r;
    wait_nxt = wait_r;
    tck_nxt = tck_r;
    tms_nxt = tms_r;
    tdi_nxt = tdi_r;
    acnt_nxt = acnt_r;
    exp_nxt = exp_r;
    vonly_nxt = vonly_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    pass_nxt = pass_r;
    idf_nxt = idf_r;
    vf_nxt = vf_r;
    faddr_nxt = faddr_r;
    img_we = 1'b0;
    f_ready = 1'b0;
    go = 1'b0;
    go_op = isp_pkg::OP_NOP;
    go_wait = CW'(MG);
    go_ret = PS_IDLE;
    case (st_r)
      PS_IDLE:
        if (start)
        begin
          busy_nxt = 1'b1;
          pass_nxt = 1'b0;
          idf_nxt = 1'b0;
          vf_nxt = 1'b0;
          vonly_nxt = verify_only;
          go = 1'b1;
          go_op = isp_pkg::OP_ENTER;
          go_wait = CW'(ENTER_CYC + MG);
          go_ret = PS_IDCODE;
        end
      PS_IDCODE:
      begin
        go = 1'b1;
        go_op = isp_pkg::OP_IDCODE;
        go_ret = PS_IDREAD;
      end
      PS_IDREAD:
      begin
        go = 1'b1;
        go_ret = PS_IDCHK;
      end
      PS_IDCHK:
      begin
        acnt_nxt = '0;
        if (cap_r[isp_pkg::ID_W-1:0] != expected_id)
        begin
          idf_nxt = 1'b1;
          st_nxt = PS_EXIT;
        end
        else
          st_nxt = vonly_r ? PS_VERIFY : PS_ERASE;
      end
      PS_ERASE:
      begin
        go = 1'b1;
        go_op = isp_pkg::OP_ERASE;
        go_wait = CW'(ERASE_CYC + MG);
        go_ret = PS_PROG;
      end
      PS_PROG:
        if (addr_end)
        begin
          acnt_nxt = '0;
          st_nxt = PS_VERIFY;
        end
        else if (f_valid)
        begin
          f_ready = 1'b1;
          img_we = 1'b1;
          go = 1'b1;
          go_op = isp_pkg::OP_PROGRAM;
          go_wait = CW'(isp_pkg::PROG_CYC + MG);
          go_ret = PS_PROG;
          acnt_nxt = acnt_r + 1'b1;
        end
      PS_VERIFY:
        if (addr_end)
          st_nxt = PS_EXIT;
        else if (!vonly_r || f_valid)
        begin
          f_ready = vonly_r;
          exp_nxt = vonly_r ? f_data : image[acnt_r[AW-1:0]];
          go = 1'b1;
          go_op = isp_pkg::OP_VERIFY;
          go_wait = CW'(isp_pkg::READ_CYC + MG);
          go_ret = PS_VREAD;
        end
      PS_VREAD:
      begin
        go = 1'b1;
        go_ret = PS_VCHK;
      end
      PS_VCHK:
      begin
        if (cap_r[DW-1:0] != exp_r && !vf_r)
        begin
          vf_nxt = 1'b1;
          faddr_nxt = acnt_r[AW-1:0];
        end
        acnt_nxt = acnt_r + 1'b1;
        st_nxt = PS_VERIFY;
      end
      PS_EXIT:
      begin
        go = 1'b1;
        go_op = isp_pkg::OP_EXIT;
        go_wait = CW'(EXIT_CYC + MG);
        go_ret = PS_DONE;
      end
      PS_SHIFT:
      begin
        ph_nxt = ph_r + 1'b1;
        if (ph_r == HALF_LAST)
        begin
          tck_nxt = 1'b1;
          cap_nxt = {tdo_sr_r[1], cap_r[FB-1:1]};
        end
        else if (ph_r == FULL_LAST)
        begin
          tck_nxt = 1'b0;
          ph_nxt = '0;
          bit_nxt = bit_r + 1'b1;
          if (bit_r == 5'(FB - 1))
          begin
            tms_nxt = 1'b0;
            st_nxt = PS_WAIT;
          end
          else
            tdi_nxt = frame_r[bit_r + 1'b1];
        end
      end
      PS_WAIT:
        // Waits are fixed pulse times plus an eight-cycle margin; shift time adds on top of them.
        if (wait_r == '0)
          st_nxt = ret_r;
        else
          wait_nxt = wait_r - 1'b1;
      PS_DONE:
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        pass_nxt = !idf_r && !vf_r;
        st_nxt = PS_IDLE;
      end
      default:
        st_nxt = PS_IDLE;
    endcase
    if (go)
    begin
      frame_nxt = '0;
      frame_nxt[isp_pkg::OP_W-1:0] = go_op;
      frame_nxt[isp_pkg::ADDR_LSB +: AW] = acnt_r[AW-1:0];
      // Only a program frame carries FIFO data; the others send zeros so the line never shows stale bytes.
      frame_nxt[isp_pkg::DATA_LSB +: DW] = (go_op == isp_pkg::OP_PROGRAM) ? f_data : '0;
      tms_nxt = 1'b1;
      tdi_nxt = frame_nxt[0];
      bit_nxt = '0;
      ph_nxt = '0;
      wait_nxt = go_wait;
      ret_nxt = go_ret;
      st_nxt = PS_SHIFT;
    end
  end

  always_ff @(posedge clk)
  begin
    tdo_sr_r <= {tdo_sr_r[0], link.tdo_pin};
    if (srst)
    begin
      st_r <= PS_IDLE;
      ret_r <= PS_IDLE;
      frame_r <= '0;
      cap_r <= '0;
      bit_r <= '0;
      ph_r <= '0;
      wait_r <= '0;
      tck_r <= 1'b0;
      tms_r <= 1'b0;
      tdi_r <= 1'b0;
      acnt_r <= '0;
      exp_r <= '0;
      vonly_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pass_r <= 1'b0;
      idf_r <= 1'b0;
      vf_r <= 1'b0;
      faddr_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      frame_r <= frame_nxt;
      cap_r <= cap_nxt;
      bit_r <= bit_nxt;
      ph_r <= ph_nxt;
      wait_r <= wait_nxt;
      tck_r <= tck_nxt;
      tms_r <= tms_nxt;
      tdi_r <= tdi_nxt;
      acnt_r <= acnt_nxt;
      exp_r <= exp_nxt;
      vonly_r <= vonly_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pass_r <= pass_nxt;
      idf_r <= idf_nxt;
      vf_r <= vf_nxt;
      faddr_r <= faddr_nxt;
    end
    if (img_we)
      image[acnt_r[AW-1:0]] <= f_data;
  end

  assign link.tck = tck_r;
  assign link.tms = tms_r;
  assign link.tdi = tdi_r;
  assign busy = busy_r;
  assign done = done_r;
  assign pass = pass_r;
  assign id_fail = idf_r;
  assign verify_fail = vf_r;
  assign fail_addr = faddr_r;
endmodule
`default_nettype wire

/* File: src/isp_pkg.sv */
// Shared constants, opcodes and timing for the in-system programming link.
package isp_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int FRAME_BITS = 20;
  localparam int OP_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ID_W = 16;
  localparam int ADDR_LSB = 4;
  localparam int DATA_LSB = 12;
  localparam int NUM_ADDR = 256;
  localparam int CNT_W = 22;
  localparam int FIFO_DEPTH = 16;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam int ENTER_TIME_US = 1000;
  localparam int EXIT_TIME_US = 1000;
  localparam int ERASE_TIME_MS = 100;
  localparam int PROG_PULSE_US = 10;
  localparam int READ_PULSE_US = 1;
  localparam int ENTER_CYC = ENTER_TIME_US * CYC_PER_US;
  localparam int EXIT_CYC = EXIT_TIME_US * CYC_PER_US;
  localparam int ERASE_CYC = ERASE_TIME_MS * 1000 * CYC_PER_US;
  localparam int PROG_CYC = PROG_PULSE_US * CYC_PER_US;
  localparam int READ_CYC = READ_PULSE_US * CYC_PER_US;
  localparam int TCK_HALF_CYC = 4;
  localparam int EXEC_MARGIN_CYC = 8;
  localparam int MACROCELLS_DEF = 64;
  localparam int BSCAN_MIN_MC = 128;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ENTER = 4'h1,
    OP_IDCODE = 4'h2,
    OP_ERASE = 4'h3,
    OP_PROGRAM = 4'h4,
    OP_VERIFY = 4'h5,
    OP_EXIT = 4'h6,
    OP_SAMPLE = 4'h7
  } isp_op_t;
endpackage

/* File: src/isp_link_if.sv */
// Four-wire test port link between programmer and device.
`timescale 1ns/1ps
`default_nettype none
interface isp_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_pin;

  // The test data output line idles high through a pull-up when undriven.
  assign tdo_pin = tdo_oe_n ? 1'b1 : tdo;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe_n
  );

  modport prog (
    output tck,
    output tms,
    output tdi,
    input tdo_pin
  );
endinterface
`default_nettype wire

/* File: src/isp_dev.sv */
// Device end: test port frame decoder, pulse timing, cell array and pin hand-over.
// Functional notes
// - Commands, addresses, data arrive serially on test input.
// - Read-back leaves serially on test output.
// - Full run six stages; verify-only four.
// - Enter moves user pins cleanly, 1 ms.
// - Programmer reads identity before program or verify.
// - Erase instruction yields one 100 ms pulse.
// - Each address programmed with its own pulse.
// - Verify: address in, read pulse, data out.
// - Exit returns user pins cleanly, 1 ms.
// - Total time is pulses plus shift cycles.
// - Test port takes four general pins.
// - Boundary scan only at 128+ macrocells.
// - Identity instruction shifts identity out serially.
// - Unused test port pins act as user pins.
`timescale 1ns/1ps
`default_nettype none
module isp_dev #(
  parameter int ENTER_CYC = isp_pkg::ENTER_CYC,
  parameter int EXIT_CYC = isp_pkg::EXIT_CYC,
  parameter int ERASE_CYC = isp_pkg::ERASE_CYC,
  parameter int MACROCELLS = isp_pkg::MACROCELLS_DEF,
  // Identity value is arbitrary.
  parameter logic [isp_pkg::ID_W-1:0] DEV_ID = 16'h5a3c
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Test port link
  isp_link_if.dev link,
  // Test port pin use
  input wire logic tp_enable,
  input wire logic user_tdo,
  input wire logic user_tdo_oe_n,
  output logic [2:0] tp_user_in,
  // User pins
  input wire logic [isp_pkg::DATA_W-1:0] user_out,
  input wire logic user_oe_n,
  output logic [isp_pkg::DATA_W-1:0] pin_out,
  output logic pin_oe_n,
  // Status
  output logic isp_mode,
  output logic busy
);
  typedef enum logic [2:0] {
    DS_USER = 3'b000,
    DS_ENTER = 3'b001,
    DS_ISP = 3'b010,
    DS_PULSE = 3'b011,
    DS_EXIT = 3'b100
  } isp_dstate_t;

  localparam int FB = isp_pkg::FRAME_BITS;
  localparam int AW = isp_pkg::ADDR_W;
  localparam int DW = isp_pkg::DATA_W;
  localparam int CW = isp_pkg::CNT_W;
  localparam bit BSCAN_ON = MACROCELLS >= isp_pkg::BSCAN_MIN_MC;

  logic [2:0] tck_sr_r;
  logic [2:0] tms_sr_r;
  logic [1:0] tdi_sr_r;
  logic rise;
  logic fend;
  isp_pkg::isp_op_t op;

  isp_dstate_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [FB-1:0] in_r, in_nxt;
  logic [FB-1:0] out_r, out_nxt;
  isp_pkg::isp_op_t op_r, op_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] data_r, data_nxt;
  logic [DW-1:0] pin_out_r, pin_out_nxt;
  logic pin_oe_n_r, pin_oe_n_nxt;
  logic tdo_r, tdo_nxt;
  logic tdo_oe_n_r, tdo_oe_n_nxt;
  logic [2:0] tp_user_in_r, tp_user_in_nxt;
  logic isp_mode_r, busy_r;
  logic erase_all;
  logic mem_we;
  logic [DW-1:0] mem [isp_pkg::NUM_ADDR];

  // Edge detection reads only the second and third stages of each synchroniser.
  assign rise = tp_enable & tck_sr_r[1] & ~tck_sr_r[2];
  assign fend = tp_enable & tms_sr_r[2] & ~tms_sr_r[1];
  assign op = isp_pkg::isp_op_t'(in_r[isp_pkg::OP_W-1:0]);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    in_nxt = in_r;
    out_nxt = out_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    pin_out_nxt = pin_out_r;
    pin_oe_n_nxt = pin_oe_n_r;
    erase_all = 1'b0;
    mem_we = 1'b0;
    if (rise && tms_sr_r[1])
    begin
      in_nxt = {tdi_sr_r[1], in_r[FB-1:1]};
      out_nxt = {1'b0, out_r[FB-1:1]};
    end
    if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
    case (st_r)
      DS_USER:
      begin
        pin_out_nxt = user_out;
        pin_oe_n_nxt = user_oe_n;
        if (fend && op == isp_pkg::OP_ENTER)
        begin
          // Pins hold their last driven values while the hand-over runs.
          st_nxt = DS_ENTER;
          cnt_nxt = CW'(ENTER_CYC - 1);
        end
      end
      DS_ENTER:
        if (cnt_r == '0)
        begin
          st_nxt = DS_ISP;
          pin_oe_n_nxt = 1'b1;
        end
      DS_ISP:
        if (fend)
        begin
          op_nxt = op;
          addr_nxt = in_r[isp_pkg::ADDR_LSB +: AW];
          data_nxt = in_r[isp_pkg::DATA_LSB +: DW];
          case (op)
            isp_pkg::OP_ERASE:
            begin
              st_nxt = DS_PULSE;
              cnt_nxt = CW'(ERASE_CYC - 1);
            end
            isp_pkg::OP_PROGRAM:
            begin
              st_nxt = DS_PULSE;
              cnt_nxt = CW'(isp_pkg::PROG_CYC - 1);
            end
            isp_pkg::OP_VERIFY:
            begin
              st_nxt = DS_PULSE;
              cnt_nxt = CW'(isp_pkg::READ_CYC - 1);
            end
            isp_pkg::OP_EXIT:
            begin
              st_nxt = DS_EXIT;
              cnt_nxt = CW'(EXIT_CYC - 1);
            end
            default:
              st_nxt = DS_ISP;
          endcase
        end
      DS_PULSE:
        if (cnt_r == '0)
        begin
          st_nxt = DS_ISP;
          case (op_r)
            isp_pkg::OP_ERASE: erase_all = 1'b1;
            isp_pkg::OP_PROGRAM: mem_we = 1'b1;
            isp_pkg::OP_VERIFY: out_nxt = FB'(mem[addr_r]);
            default: st_nxt = DS_ISP;
          endcase
        end
      DS_EXIT:
        // Pins stay released until the full exit time has passed.
        if (cnt_r == '0)
          st_nxt = DS_USER;
      default:
        st_nxt = DS_USER;
    endcase
    if (fend && op == isp_pkg::OP_IDCODE)
      out_nxt = FB'(DEV_ID);
    else if (fend && op == isp_pkg::OP_SAMPLE && BSCAN_ON)
      out_nxt = FB'(user_out);
    tdo_nxt = tp_enable ? out_nxt[0] : user_tdo;
    tdo_oe_n_nxt = tp_enable ? 1'b0 : user_tdo_oe_n;
    tp_user_in_nxt = tp_enable ? 3'b000 : {tck_sr_r[1], tms_sr_r[1], tdi_sr_r[1]};
  end

  always_ff @(posedge clk)
  begin
    tck_sr_r <= {tck_sr_r[1:0], link.tck};
    tms_sr_r <= {tms_sr_r[1:0], link.tms};
    tdi_sr_r <= {tdi_sr_r[0], link.tdi};
    if (srst)
    begin
      st_r <= DS_USER;
      cnt_r <= '0;
      in_r <= '0;
      out_r <= '0;
      op_r <= isp_pkg::OP_NOP;
      addr_r <= '0;
      data_r <= '0;
      pin_out_r <= '0;
      pin_oe_n_r <= 1'b1;
      tdo_r <= 1'b1;
      tdo_oe_n_r <= 1'b1;
      tp_user_in_r <= '0;
      isp_mode_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      in_r <= in_nxt;
      out_r <= out_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_n_r <= tdo_oe_n_nxt;
      tp_user_in_r <= tp_user_in_nxt;
      isp_mode_r <= (st_nxt == DS_ISP) || (st_nxt == DS_PULSE);
      busy_r <= (st_nxt == DS_ENTER) || (st_nxt == DS_PULSE) || (st_nxt == DS_EXIT);
    end
  end

  // The cell array has no reset; only the erase pulse sets every cell to a known value.
  always_ff @(posedge clk)
  begin
    if (erase_all)
    begin
      for (int i = 0; i < isp_pkg::NUM_ADDR; i++)
        mem[i] <= isp_pkg::ERASED_BYTE;
    end
    else if (mem_we)
      mem[addr_r] <= data_r;
  end

  assign link.tdo = tdo_r;
  assign link.tdo_oe_n = tdo_oe_n_r;
  assign tp_user_in = tp_user_in_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign isp_mode = isp_mode_r;
  assign busy = busy_r;
endmodule
`default_nettype wire

/* File: bench/isp_link_props.sv */
// Concurrent checks on the test port link between the programmer and the device.
`timescale 1ns/1ps
`default_nettype none
module isp_link_props #(
  parameter int ENTER_CYC = isp_pkg::ENTER_CYC,
  parameter int ERASE_CYC = isp_pkg::ERASE_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link signals
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic tdo_pin
);
  logic tck_r, tck_nxt, tms_r, tms_nxt;
  logic [4:0] rises_r, rises_nxt;
  logic [19:0] sh_r, sh_nxt;
  logic [3:0] op_r, op_nxt;
  logic [21:0] gap_r, gap_nxt;

  // Rebuilds each frame from the wire and times the quiet gap that follows it.
  always_comb
  begin
    tck_nxt = tck;
    tms_nxt = tms;
    rises_nxt = tms ? rises_r + 5'(tck && !tck_r) : 5'h00;
    sh_nxt = (tms && tck && !tck_r) ? {tdi, sh_r[19:1]} : sh_r;
    op_nxt = (tms_r && !tms) ? sh_r[3:0] : op_r;
    gap_nxt = tms ? 22'h000000 : gap_r + 22'h000001;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {tck_r, tms_r, rises_r, sh_r, op_r, gap_r} <= '0;
    end
    else
    begin
      {tck_r, tms_r, rises_r, sh_r, op_r, gap_r} <= {tck_nxt, tms_nxt, rises_nxt, sh_nxt, op_nxt, gap_nxt};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence frame_end;
    tms_r && !tms;
  endsequence
  sequence high_phase;
    tck[*4] ##1 !tck;
  endsequence

  tck_idle_a: assert property (tck |-> tms)
    else $error("test clock high outside a frame");
  tck_half_a: assert property ($rose(tck) |-> high_phase)
    else $error("test clock high phase is not four cycles");
  tdi_hold_a: assert property (tck |-> $stable(tdi))
    else $error("serial input moved while the test clock was high");
  frame_start_a: assert property ($rose(tms) |-> !tck[*4])
    else $error("first test clock rise came too early in a frame");
  frame_len_a: assert property (frame_end |-> rises_r == 5'(isp_pkg::FRAME_BITS))
    else $error("frame did not carry twenty bits");
  frame_gap_a: assert property (frame_end |-> !tms[*8])
    else $error("next frame came before the pulse margin");
  enter_wait_a: assert property ($rose(tms) && op_r == isp_pkg::OP_ENTER |-> gap_r >= 22'(ENTER_CYC))
    else $error("frame followed entry before the entry time");
  erase_wait_a: assert property ($rose(tms) && op_r == isp_pkg::OP_ERASE |-> gap_r >= 22'(ERASE_CYC))
    else $error("frame followed erase before the erase pulse");
  reset_idle_a: assert property (disable iff (1'b0) srst |=> !tck && !tms && tdo_oe_n)
    else $error("link not idle after reset");
  tdo_drive_a: assert property (tms |-> !tdo_oe_n && tdo_pin == tdo)
    else $error("device not driving the serial output during a frame");
  erase_seen_c: cover property ($rose(tms) && op_r == isp_pkg::OP_ERASE);
endmodule
`default_nettype wire

/* File: bench/test_jtag_isp_program_sequence.sv */
// Self-checking bench: programmer and device joined, plus a bench-driven second device.
`timescale 1ns/1ps
`default_nettype none
module test_jtag_isp_program_sequence;
  localparam int ENT = 200;
  localparam int EXT = 200;
  localparam int ERS = 2000;
  // Identity value is arbitrary.
  localparam logic [15:0] ID_VAL = 16'hc35a;
  logic clk, srst, start, verify_only, wr_valid, wr_ready, u_tdo, u_tdo_oe_n, user_oe_n, tp_en2;
  logic pin_oe_n, pin_oe_n2, isp_mode, isp_mode2, dbusy, dbusy2, pbusy, done, pass, id_fail, verify_fail;
  logic [7:0] wr_data, user_out, pin_out, pin_out2, fail_addr;
  logic [15:0] exp_id;
  logic [2:0] tp_in, tp_in2;
  logic [19:0] q;
  logic [31:0] rnd;
  logic [7:0] pat [256];
  int error_cnt = 0;
  int checked = 0;
  int cyc, bad;
  isp_link_if l1();
  isp_link_if l2();
  isp_dev #(.ENTER_CYC(ENT), .EXIT_CYC(EXT), .ERASE_CYC(ERS), .DEV_ID(ID_VAL)) isp_dev_i (.clk(clk), .srst(srst),
    .link(l1.dev), .tp_enable(1'b1), .user_tdo(u_tdo), .user_tdo_oe_n(u_tdo_oe_n), .tp_user_in(tp_in),
    .user_out(user_out), .user_oe_n(user_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .isp_mode(isp_mode),
    .busy(dbusy));
  isp_dev #(.ENTER_CYC(ENT), .EXIT_CYC(EXT), .ERASE_CYC(ERS), .MACROCELLS(isp_pkg::BSCAN_MIN_MC), .DEV_ID(ID_VAL))
    isp_dev_solo_i (.clk(clk), .srst(srst),
    .link(l2.dev), .tp_enable(tp_en2), .user_tdo(u_tdo), .user_tdo_oe_n(u_tdo_oe_n), .tp_user_in(tp_in2),
    .user_out(user_out), .user_oe_n(user_oe_n), .pin_out(pin_out2), .pin_oe_n(pin_oe_n2), .isp_mode(isp_mode2),
    .busy(dbusy2));
  isp_prog #(.ENTER_CYC(ENT), .EXIT_CYC(EXT), .ERASE_CYC(ERS)) isp_prog_i (.clk(clk), .srst(srst), .link(l1.prog),
    .start(start), .verify_only(verify_only), .expected_id(exp_id), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .busy(pbusy), .done(done), .pass(pass), .id_fail(id_fail), .verify_fail(verify_fail),
    .fail_addr(fail_addr));
  isp_link_props #(.ENTER_CYC(ENT), .ERASE_CYC(ERS)) isp_link_props_i (.clk(clk), .srst(srst), .tck(l1.tck),
    .tms(l1.tms), .tdi(l1.tdi), .tdo(l1.tdo), .tdo_oe_n(l1.tdo_oe_n), .tdo_pin(l1.tdo_pin));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Lower bound of a full run: fixed pulse times plus 516 frames of 160 cycles each.
  function automatic int min_run();
    return ENT + EXT + ERS + 256 * (isp_pkg::PROG_CYC + isp_pkg::READ_CYC) + 516 * 160;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Shifts one frame LSB first at a 320 ns test clock; each output bit is read just before its rise.
  task automatic frame2(input logic [19:0] f, output logic [19:0] r);
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk);
      {l2.tms, l2.tck, l2.tdi} = {2'b10, f[i]};
      repeat (4) @(negedge clk);
      r[i] = l2.tdo_pin;
      l2.tck = 1'b1;
      repeat (3) @(negedge clk);
    end
    @(negedge clk);
    {l2.tms, l2.tck, l2.tdi} = {2'b00, ~l2.tdi};
    repeat (40) @(negedge clk);
  endtask

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = b;
    while (wr_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask

  // Feeds the pattern with random stalls; a bad index and address 255 get inverted bytes.
  task automatic feed(input int n0, input int bad_at);
    for (int n = n0; n < 256; n++)
    begin
      rnd = xs(rnd);
      if (rnd[1:0] == 2'b00)
        repeat (rnd[6:2]) @(negedge clk);
      push(pat[n] ^ ((n == bad_at || (bad_at >= 0 && n == 255)) ? 8'hff : 8'h00));
    end
  endtask

  task automatic run(input logic vo);
    @(negedge clk);
    {start, verify_only} = {1'b1, vo};
    @(negedge clk);
    start = 1'b0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 400000)
    begin
      @(negedge clk);
      cyc++;
    end
    check(done, 1'b1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // About 300k cycles are expected; the limit of 750k leaves more than twice that.
  initial
  begin
    #30_000_000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    {srst, u_tdo} = 2'b11;
    {start, verify_only, wr_valid, u_tdo_oe_n, user_oe_n, tp_en2, wr_data, user_out} = '0;
    {l2.tck, l2.tms, l2.tdi} = 3'b101;
    exp_id = ID_VAL;
    rnd = 32'h00000040;
    repeat (2) @(negedge clk);
    check({pin_oe_n, isp_mode, pbusy, done, l1.tdo_oe_n, l1.tck, l1.tms}, 7'b1000100);
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rnd = xs(rnd);
    user_out = rnd[7:0];
    repeat (4) @(negedge clk);
    check({pin_oe_n, pin_out, tp_in}, {1'b0, user_out, 3'b000});
    check({tp_in2, l2.tdo_oe_n, l2.tdo, pin_out2}, {3'b101, 1'b0, 1'b1, user_out});
    {l2.tck, l2.tms, l2.tdi, tp_en2} = 4'b0001;
    repeat (4) @(negedge clk);
    frame2({16'h0000, isp_pkg::OP_ERASE}, q);
    check({dbusy2, isp_mode2}, 2'b00);
    frame2({16'h0000, isp_pkg::OP_ENTER}, q);
    repeat (ENT) @(negedge clk);
    check({isp_mode2, pin_oe_n2}, 2'b11);
    frame2({16'h0000, isp_pkg::OP_IDCODE}, q);
    frame2({16'h0000, isp_pkg::OP_NOP}, q);
    check(q[15:0], ID_VAL);
    // This device is built large enough for boundary scan, so a snapshot returns the user pins.
    frame2({16'h0000, isp_pkg::OP_SAMPLE}, q);
    frame2({16'h0000, isp_pkg::OP_NOP}, q);
    check(q, {12'h000, user_out});
    frame2({16'h0000, isp_pkg::OP_EXIT}, q);
    repeat (EXT + 20) @(negedge clk);
    check({isp_mode2, pin_oe_n2}, 2'b00);
    exp_id = ID_VAL ^ 16'h0001;
    run(1'b0);
    check(32'(cyc < ERS), 32'd1);
    repeat (20) @(negedge clk);
    check({id_fail, pass, isp_mode}, 3'b100);
    exp_id = ID_VAL;
    for (int i = 0; i < 256; i++)
    begin
      rnd = xs(rnd);
      pat[i] = rnd[7:0];
    end
    for (int i = 0; i < 16; i++)
      push(pat[i]);
    @(negedge clk);
    {wr_valid, wr_data} = {1'b1, pat[16]};
    repeat (3) @(negedge clk);
    check(wr_ready, 1'b0);
    wr_valid = 1'b0;
    fork
      run(1'b0);
      feed(16, -1);
      begin
        repeat (ENT + 700) @(negedge clk);
        check({isp_mode, pin_oe_n, pbusy, dbusy}, 4'b1111);
      end
    join
    check(32'(cyc >= min_run()), 32'd1);
    repeat (20) @(negedge clk);
    check({pass, verify_fail, id_fail, isp_mode, pin_oe_n, pin_out}, {5'b10000, user_out});
    rnd = xs(rnd);
    bad = int'(rnd[6:0]);
    fork
      run(1'b1);
      feed(0, bad);
    join
    check({pass, verify_fail, fail_addr}, {2'b01, 8'(bad)});
    print_verdict();
  end
endmodule
`default_nettype wire
